// File: verilog/sacs_device.sv
// Converter end: power-up pulse, gated start, busy framing, output register
`timescale 1ns/1ps
`default_nettype none
module sacs_device
  import sacs_pkg::*;
#(
  parameter int PULSE_CYCLES = POWERUP_CYC,
  parameter int CONV_CYCLES = CONV_CYC
) (
  input wire logic clock,
  input wire logic rst,
  sacs_link_if.dev link,
  input wire logic [DATA_W-1:0] sample_code,
  output logic powered_down,
  output logic high_speed,
  output logic [DATA_W-1:0] result
);

  // ********************************************************************
  // State record
  // ********************************************************************
  typedef struct packed {
    sacs_dev_state_t state;
    logic start_prev;
    logic gated_prev;
    logic [CNT_W-1:0] pulse_cnt;
    logic [CNT_W-1:0] conv_cnt;
    logic [DATA_W-1:0] held;
    logic [DATA_W-1:0] result;
    logic busy;
    logic drive_en;
    logic power_down;
    logic high_speed;
  } sacs_dev_st_t;

  localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(PULSE_CYCLES);
  localparam logic [CNT_W-1:0] CONV_LOAD = CNT_W'(CONV_CYCLES);

  sacs_dev_st_t st_ff;
  sacs_dev_st_t nxt_st;

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  logic [2:0] pins_raw;
  logic [2:0] pins_sync;
  logic start_lvl;
  logic select_n;
  logic read_n;

  assign pins_raw = {link.convert_start_n, link.chip_select_n, link.read_strobe_n};

  // Start idles low at power-on; strobes idle high
  sacs_sync2 #(
    .W(3),
    .RST_VAL(3'h3)
  ) u_pin_sync (
    .clock(clock),
    .rst(rst),
    .d(pins_raw),
    .q(pins_sync)
  );

  assign start_lvl = pins_sync[2];
  assign select_n = pins_sync[1];
  assign read_n = pins_sync[0];

  // ********************************************************************
  // Derived events
  // ********************************************************************
  logic start_rise;
  logic pulse_on;
  logic gated;
  logic gated_fall;
  logic conv_done;

  // Edge detectors look only at the second synchroniser stage
  assign start_rise = start_lvl & ~st_ff.start_prev;
  assign pulse_on = (st_ff.pulse_cnt != '0);
  assign gated = start_lvl | pulse_on;
  assign gated_fall = st_ff.gated_prev & ~gated;
  assign conv_done = (st_ff.state == SACS_CONV) && (st_ff.conv_cnt == CNT_W'(1));

  // ********************************************************************
  // Next-state logic
  // ********************************************************************
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.start_prev = start_lvl;
    nxt_st.gated_prev = gated;

    // Each rising start edge reloads the power-up pulse
    if (start_rise)
    begin
      nxt_st.pulse_cnt = PULSE_LOAD;
    end
    else if (pulse_on)
    begin
      nxt_st.pulse_cnt = st_ff.pulse_cnt - CNT_W'(1);
    end

    unique case (st_ff.state)
      SACS_DOWN:
      begin
        // Low-current state; only a rising start edge wakes it
        if (start_rise)
        begin
          nxt_st.state = SACS_UP;
          nxt_st.power_down = 1'b0;
        end
      end
      SACS_UP:
      begin
        // The gated signal falls on whichever of pulse end or pin fall is later,
        // which covers both the start-already-low and start-still-high cases
        if (gated_fall)
        begin
          nxt_st.state = SACS_CONV;
          nxt_st.busy = 1'b1;
          nxt_st.held = sample_code;
          nxt_st.conv_cnt = CONV_LOAD;
          nxt_st.drive_en = 1'b0;
        end
      end
      SACS_CONV:
      begin
        nxt_st.conv_cnt = st_ff.conv_cnt - CNT_W'(1);
        if (conv_done)
        begin
          nxt_st.busy = 1'b0;
          nxt_st.result = st_ff.held;
          if (start_lvl)
          begin
            nxt_st.state = SACS_UP;
            nxt_st.high_speed = 1'b1;
          end
          else
          begin
            nxt_st.state = SACS_DOWN;
            nxt_st.high_speed = 1'b0;
            nxt_st.power_down = 1'b1;
          end
        end
      end
      default:
      begin
        nxt_st.state = SACS_DOWN;
        nxt_st.power_down = 1'b1;
      end
    endcase

    // Read port works in every state but conversion, power-down included; it stays reset
    // for the whole busy frame so a stray read never sees a half result
    if (!nxt_st.busy)
    begin
      nxt_st.drive_en = ~select_n & ~read_n;
    end
    else
    begin
      nxt_st.drive_en = 1'b0;
    end
  end

  // ********************************************************************
  // State register
  // ********************************************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_ff.state <= SACS_DOWN;
      st_ff.start_prev <= 1'b0;
      st_ff.gated_prev <= 1'b0;
      st_ff.pulse_cnt <= '0;
      st_ff.conv_cnt <= '0;
      st_ff.held <= RESULT_RST;
      st_ff.result <= RESULT_RST;
      st_ff.busy <= 1'b0;
      st_ff.drive_en <= 1'b0;
      st_ff.power_down <= 1'b1;
      st_ff.high_speed <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ********************************************************************
  // Outputs, all straight from the state record
  // ********************************************************************
  // Data lines always carry the output register; the enable gates the bus
  assign link.busy = st_ff.busy;
  assign link.data_dev = st_ff.result;
  assign link.data_oe = st_ff.drive_en;
  assign powered_down = st_ff.power_down;
  assign high_speed = st_ff.high_speed;
  assign result = st_ff.result;

endmodule : sacs_device
`default_nettype wire

// File: verilog/sacs_pkg.sv
// Shared constants and types for the conversion sequencer and its host end
`default_nettype none
package sacs_pkg;

  // ********************************************************************
  // Clock and timing
  // ********************************************************************
  localparam int CLK_PERIOD_NS = 50;
  // Power-up pulse: least time, so round up
  localparam int POWERUP_NS = 1500;
  localparam int POWERUP_CYC = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Conversion period of the on-chip oscillator model
  localparam int CONV_NS = 4500;
  localparam int CONV_CYC = (CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Host wake pulse: kept at or below the power-up time, so round down
  localparam int WAKE_NS = 500;
  localparam int WAKE_CYC = WAKE_NS / CLK_PERIOD_NS;
  // Host spacing after a read before the next start edge
  localparam int READ_GAP_NS = 100;
  localparam int READ_GAP_CYC = (READ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Host low time on convert start and read strobe length
  localparam int START_LOW_CYC = 2;
  localparam int READ_CYC = 6;

  // ********************************************************************
  // Widths and reset values
  // ********************************************************************
  localparam int DATA_W = 8;
  localparam int CNT_W = 8;
  localparam logic [DATA_W-1:0] RESULT_RST = 8'h00;
  localparam logic [DATA_W-1:0] BUS_IDLE = 8'hff;

  // Device power and conversion states
  typedef enum logic [1:0] {
    SACS_DOWN = 2'b00,
    SACS_UP = 2'b01,
    SACS_CONV = 2'b10
  } sacs_dev_state_t;

  // Host sequencing states
  typedef enum logic [2:0] {
    SACS_H_IDLE = 3'b000,
    SACS_H_WAKE = 3'b001,
    SACS_H_LOW = 3'b010,
    SACS_H_BUSY_HI = 3'b011,
    SACS_H_BUSY_LO = 3'b100,
    SACS_H_READ = 3'b101,
    SACS_H_GAP = 3'b110
  } sacs_host_state_t;

endpackage : sacs_pkg
`default_nettype wire

// File: verilog/sacs_link_if.sv
// Pin-level link between the converter and the host processor
`timescale 1ns/1ps
`default_nettype none
interface sacs_link_if
  import sacs_pkg::*;
();
  logic convert_start_n;
  logic chip_select_n;
  logic read_strobe_n;
  logic busy;
  logic [DATA_W-1:0] data_dev;
  logic data_oe;
  wire [DATA_W-1:0] data_bus;

  // Undriven bus floats to the pulled-up idle level
  assign data_bus = data_oe ? data_dev : BUS_IDLE;

  modport dev (
    input convert_start_n,
    input chip_select_n,
    input read_strobe_n,
    output busy,
    output data_dev,
    output data_oe
  );

  modport host (
    output convert_start_n,
    output chip_select_n,
    output read_strobe_n,
    input busy,
    input data_bus
  );
endinterface : sacs_link_if
`default_nettype wire

// File: verilog/sacs_sync2.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sacs_sync2
  import sacs_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stage;
  } sacs_sync_st_t;

  sacs_sync_st_t st_ff;
  sacs_sync_st_t nxt_st;

  // First stage feeds only the second
  always_comb
  begin
    nxt_st.meta = d;
    nxt_st.stage = st_ff.meta;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= {RST_VAL, RST_VAL};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.stage;

endmodule : sacs_sync2
`default_nettype wire

// File: verilog/sacs_host.sv
// Host end: drives convert start, waits for busy, reads the result
`timescale 1ns/1ps
`default_nettype none
module sacs_host
  import sacs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  sacs_link_if.host link,
  input wire logic start_req,
  input wire logic auto_power_down,
  output logic ready,
  output logic result_valid,
  output logic [DATA_W-1:0] result_data
);

  // ********************************************************************
  // State record
  // ********************************************************************
  typedef struct packed {
    sacs_host_state_t state;
    logic [CNT_W-1:0] cnt;
    logic auto_mode;
    logic dev_up;
    logic start_n;
    logic sel_n;
    logic rd_n;
    logic ready;
    logic valid;
    logic [DATA_W-1:0] data;
  } sacs_host_st_t;

  sacs_host_st_t st_ff;
  sacs_host_st_t nxt_st;
  logic [DATA_W:0] pins_sync;
  logic busy_s;

  // Busy and data come from the far end, so both are resynchronised
  sacs_sync2 #(
    .W(DATA_W + 1),
    .RST_VAL({1'b0, BUS_IDLE})
  ) u_in_sync (
    .clock(clock),
    .rst(rst),
    .d({link.busy, link.data_bus}),
    .q(pins_sync)
  );

  assign busy_s = pins_sync[DATA_W];

  // ********************************************************************
  // Sequencer
  // ********************************************************************
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.valid = 1'b0;
    if (st_ff.cnt != '0)
    begin
      nxt_st.cnt = st_ff.cnt - CNT_W'(1);
    end
    unique case (st_ff.state)
      SACS_H_IDLE:
      begin
        if (start_req)
        begin
          nxt_st.ready = 1'b0;
          nxt_st.auto_mode = auto_power_down;
          // A sleeping device needs a rising edge before it can convert
          nxt_st.state = st_ff.dev_up ? SACS_H_LOW : SACS_H_WAKE;
          nxt_st.start_n = ~st_ff.dev_up;
          nxt_st.cnt = st_ff.dev_up ? CNT_W'(START_LOW_CYC) : CNT_W'(WAKE_CYC);
        end
      end
      SACS_H_WAKE:
      begin
        if (st_ff.cnt == CNT_W'(1))
        begin
          nxt_st.start_n = 1'b0;
          nxt_st.state = SACS_H_LOW;
        end
      end
      SACS_H_LOW:
      begin
        if (busy_s)
        begin
          // Auto mode keeps start low through busy fall; high-speed raises it
          nxt_st.start_n = ~st_ff.auto_mode;
          nxt_st.state = SACS_H_BUSY_LO;
        end
      end
      SACS_H_BUSY_LO:
      begin
        if (!busy_s)
        begin
          nxt_st.dev_up = ~st_ff.auto_mode;
          nxt_st.sel_n = 1'b0;
          nxt_st.rd_n = 1'b0;
          nxt_st.cnt = CNT_W'(READ_CYC);
          nxt_st.state = SACS_H_READ;
        end
      end
      SACS_H_READ:
      begin
        if (st_ff.cnt == CNT_W'(1))
        begin
          nxt_st.data = pins_sync[DATA_W-1:0];
          nxt_st.valid = 1'b1;
          nxt_st.sel_n = 1'b1;
          nxt_st.rd_n = 1'b1;
          nxt_st.cnt = CNT_W'(READ_GAP_CYC);
          nxt_st.state = SACS_H_GAP;
        end
      end
      SACS_H_GAP:
      begin
        // Read ends well before any later start edge
        if (st_ff.cnt == '0)
        begin
          nxt_st.ready = 1'b1;
          nxt_st.state = SACS_H_IDLE;
        end
      end
      default:
      begin
        nxt_st.state = SACS_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_ff.state <= SACS_H_IDLE;
      st_ff.cnt <= '0;
      st_ff.auto_mode <= 1'b0;
      st_ff.dev_up <= 1'b0;
      st_ff.start_n <= 1'b0;
      st_ff.sel_n <= 1'b1;
      st_ff.rd_n <= 1'b1;
      st_ff.ready <= 1'b1;
      st_ff.valid <= 1'b0;
      st_ff.data <= RESULT_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign link.convert_start_n = st_ff.start_n;
  assign link.chip_select_n = st_ff.sel_n;
  assign link.read_strobe_n = st_ff.rd_n;
  assign ready = st_ff.ready;
  assign result_valid = st_ff.valid;
  assign result_data = st_ff.data;

endmodule : sacs_host
`default_nettype wire

// File: verification/sacs_sva.sv
// Concurrent checks on the pin link between converter and host
`timescale 1ns/1ps
`default_nettype none
module sacs_sva
  import sacs_pkg::*;
#(
  parameter int PULSE_CYCLES = POWERUP_CYC,
  parameter int CONV_CYCLES = CONV_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic convert_start_n,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic busy,
  input wire logic [DATA_W-1:0] data_dev,
  input wire logic data_oe,
  input wire logic [DATA_W-1:0] data_bus
);
  // ********************
  // Helper counters
  // ********************
  logic rd_low;
  logic start_q_ff;
  logic [CNT_W-1:0] busy_cnt_ff;
  logic [CNT_W-1:0] since_rise_ff;

  // Both read pins asserted
  assign rd_low = !chip_select_n && !read_strobe_n;

  // Busy length and time since start rose; the latter saturates so long idles cannot wrap
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      start_q_ff <= 1'b0;
      busy_cnt_ff <= 8'h00;
      since_rise_ff <= 8'h00;
    end
    else
    begin
      start_q_ff <= convert_start_n;
      busy_cnt_ff <= busy ? busy_cnt_ff + 8'h01 : 8'h00;
      if (convert_start_n && !start_q_ff)
        since_rise_ff <= 8'h00;
      else if (since_rise_ff != 8'hff)
        since_rise_ff <= since_rise_ff + 8'h01;
    end
  end

  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  busy_length_a: assert property ($fell(busy) |-> busy_cnt_ff == CONV_CYCLES)
    else $error("busy high for a wrong number of cycles");
  pulse_wait_a: assert property ($rose(busy) |-> since_rise_ff >= PULSE_CYCLES)
    else $error("conversion began inside the power-up pulse");
  start_low_a: assert property ($rose(busy) |-> !convert_start_n)
    else $error("conversion began with start high");
  port_reset_a: assert property ($rose(busy) |=> !data_oe)
    else $error("read port still driving after busy rose");
  oe_cause_a: assert property (data_oe |-> $past(rd_low, 3))
    else $error("data driven without select and read");
  oe_rise_a: assert property ((rd_low && !busy) [*4] |-> data_oe)
    else $error("read not answered");
  oe_hold_a: assert property (data_oe && $past(data_oe) |-> $stable(data_dev) && data_bus == data_dev)
    else $error("output register changed during a read");
  read_idle_a: assert property (rd_low |-> !busy)
    else $error("host read while busy");
  start_space_a: assert property ($fell(convert_start_n) |-> chip_select_n && read_strobe_n)
    else $error("start fell during a read");
endmodule : sacs_sva
`default_nettype wire

// File: verification/test_sar_adc_conversion_sequencer.sv
// Self-checking bench joining the converter end and the host end
`timescale 1ns/1ps
`default_nettype none
module test_sar_adc_conversion_sequencer
  import sacs_pkg::*;
();
  // Pulse shorter than conversion so a start rise in mid-conversion expires
  localparam int PULSE_T = 20;
  localparam int CONV_T = 40;
  // One bit per request: 1 auto power-down, 0 high speed
  localparam logic [7:0] MODES = 8'hc7;
  logic clock;
  logic rst;
  logic start_req;
  logic auto_power_down;
  logic [DATA_W-1:0] sample_code;
  logic powered_down;
  logic high_speed;
  logic [DATA_W-1:0] result;
  logic ready;
  logic result_valid;
  logic [DATA_W-1:0] result_data;
  logic [DATA_W-1:0] exp_q[$];
  int errors;
  int compares;

  // ********************
  // Ends, link and checker
  // ********************
  sacs_link_if link();
  sacs_device #(.PULSE_CYCLES(PULSE_T), .CONV_CYCLES(CONV_T)) i_sacs_device (
    .clock(clock), .rst(rst), .link(link), .sample_code(sample_code),
    .powered_down(powered_down), .high_speed(high_speed), .result(result));
  sacs_host i_sacs_host (
    .clock(clock), .rst(rst), .link(link), .start_req(start_req),
    .auto_power_down(auto_power_down), .ready(ready), .result_valid(result_valid),
    .result_data(result_data));
  sacs_sva #(.PULSE_CYCLES(PULSE_T), .CONV_CYCLES(CONV_T)) i_sacs_sva (
    .clock(clock), .rst(rst), .convert_start_n(link.convert_start_n),
    .chip_select_n(link.chip_select_n), .read_strobe_n(link.read_strobe_n),
    .busy(link.busy), .data_dev(link.data_dev), .data_oe(link.data_oe),
    .data_bus(link.data_bus));

  // ********************
  // Shared tasks
  // ********************
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  // One request; the input moves after hold and a second request is knocked in
  task automatic run_conv(input logic mode);
    logic [DATA_W-1:0] code;
    int n;
    code = DATA_W'($urandom);
    @(negedge clock);
    sample_code = code;
    auto_power_down = mode;
    start_req = 1'b1;
    exp_q.push_back(code);
    @(negedge clock);
    start_req = 1'b0;
    for (n = 0; n < 400 && link.busy !== 1'b1; n++)
      @(negedge clock);
    sample_code = ~code;
    start_req = 1'b1;
    @(negedge clock);
    start_req = 1'b0;
    for (n = 0; n < 400 && ready !== 1'b1; n++)
      @(negedge clock);
    // Both mode flags checked so a stale high-speed flag after auto mode is caught
    check({6'h00, powered_down, high_speed}, {6'h00, mode, ~mode});
    if (!mode)
      check({7'h00, high_speed}, 8'h01);
  endtask : run_conv

  // ********************
  // Clock, stimulus, monitor, watchdog
  // ********************
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Reset, then auto, high-speed back-to-back, and back to auto
  initial
  begin
    errors = 0;
    compares = 0;
    rst = 1'b1;
    start_req = 1'b0;
    auto_power_down = 1'b1;
    sample_code = 8'h00;
    void'($urandom(32'h3e1f24b2));
    repeat (6) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    check({6'h00, powered_down, high_speed}, 8'h02);
    for (int i = 0; i < 8; i++)
      run_conv(MODES[i]);
    repeat (5) @(negedge clock);
    // Every noted sample must have been matched by a host result
    check(DATA_W'(exp_q.size()), 8'h00);
    print_verdict();
  end

  // Each host result is matched to the oldest noted sample; looked at
  // mid-cycle, where the one-cycle valid pulse has settled
  always @(negedge clock)
  begin
    if (result_valid === 1'b1)
    begin
      check({7'h00, exp_q.size() != 0}, 8'h01);
      if (exp_q.size() != 0)
      begin
        check(result_data, exp_q[0]);
        check(result, exp_q.pop_front());
      end
    end
  end

  // Eight requests of under 150 cycles each; generous margin
  initial
  begin
    #(4000 * CLK_PERIOD_NS);
    errors++;
    print_verdict();
  end
endmodule : test_sar_adc_conversion_sequencer
`default_nettype wire
